// ===== design/crc_engine.sv
// checksum engine: register port, data queue and byte-wide stepper
//
// The register offsets and the plain strobed port are this design's own decisions.
`default_nettype none

// How it works
// R01 - Software picks one of three fixed generators, CCITT, 16 or 32.
// R02 - The CCITT choice divides by x16 + x12 + x5 + 1.
// R03 - The 16-bit choice divides by x16 + x15 + x2 + 1.
// R04 - The 32-bit choice divides by the usual fifteen-term generator.
// R05 - Input bytes and the final sum can each be reversed and inverted.
// R06 - Writing the seed register loads the accumulator before data.
// R07 - Data arrives by single writes or back-to-back queued writes.
// R08 - A data write is 8, 16 or 32 bits and exactly that many are used.
// R09 - A byte write is folded into the sum in one clock.
// R10 - A halfword write takes two byte steps, two clocks.
// R11 - A word write takes four byte steps, four clocks.
// R12 - A fourth choice uses a generator written by software.
// R13 - Bytes go lowest first; read the sum once the busy bit is clear.

module crc_engine #(
  parameter int unsigned FIFO_DEPTH = crc_pkg::FIFO_DEPTH
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_b,
  input  wire logic [crc_pkg::ADDR_W-1:0] i_addr,
  input  wire logic [31:0]                i_wdata,
  input  wire logic [1:0]                 i_size,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output logic      [31:0]                o_rdata,
  output logic                            o_data_ready
);

  // ----------------------------------------------------------------
  // parameter checks and local widths
  // ----------------------------------------------------------------
  localparam int unsigned EW = 2 + crc_pkg::DATA_W; // size + data
  localparam int unsigned LW = $clog2(FIFO_DEPTH + 1);

  if (LW > 8) begin : g_bad_depth
    $error("crc_engine queue level must fit the status field");
  end

  typedef enum logic {ST_IDLE, ST_RUN} eng_state_t;

  typedef struct packed {
    eng_state_t  state;
    logic [1:0]  sel;
    logic        in_rev;
    logic        in_cmp;
    logic        out_rev;
    logic        out_cmp;
    logic [31:0] poly;
    logic [31:0] acc;
    logic [31:0] sh;
    logic [2:0]  cnt;
    logic        ovf;
    logic [31:0] rdata;
  } eng_st_t;

  localparam eng_st_t RST = '{
    state:   ST_IDLE,
    sel:     crc_pkg::SEL_RST,
    in_rev:  1'b0,
    in_cmp:  1'b0,
    out_rev: 1'b0,
    out_cmp: 1'b0,
    poly:    crc_pkg::POLY_RST,
    acc:     crc_pkg::SEED_RST,
    sh:      32'h0000_0000,
    cnt:     3'h0,
    ovf:     1'b0,
    rdata:   32'h0000_0000
  };

  eng_st_t        st_q;
  eng_st_t        st_d;

  logic           wr_data;
  logic           size_ok;
  logic           push;
  logic           f_ready;
  logic           f_valid;
  logic [EW-1:0]  f_data;
  logic [LW-1:0]  f_level;
  logic           pop;
  logic           step;
  logic           wide16;
  logic [31:0]    poly_w;
  logic [7:0]     tb;
  logic [2:0]     nbytes;
  logic [31:0]    sum_plain;
  logic [31:0]    sum_out;

  // ----------------------------------------------------------------
  // one byte through the divider, msb first, left-aligned
  // ----------------------------------------------------------------
  function automatic logic [31:0] crc_step(
    input logic [31:0] c,
    input logic [7:0]  b,
    input logic [31:0] p
  );
    logic [31:0] r;
    r = c ^ {b, 24'h00_0000};
    for (int i = 0; i < 8; i++) begin
      r = r[31] ? ((r << 1) ^ p) : (r << 1);
    end
    return r;
  endfunction : crc_step

  // ----------------------------------------------------------------
  // data queue: writes land here, the stepper drains it
  // ----------------------------------------------------------------
  assign wr_data = i_wr && (i_addr == crc_pkg::ADDR_DATA);
  assign size_ok = (i_size != 2'h3);
  assign push    = wr_data && size_ok; // R07

  crc_fifo #(
    .WIDTH (EW),
    .DEPTH (FIFO_DEPTH)
  ) u_queue (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_valid (push),
    .i_data  ({i_size, i_wdata}),
    .o_ready (f_ready),
    .o_valid (f_valid),
    .o_data  (f_data),
    .i_ready (pop),
    .o_level (f_level)
  );

  // dma paces itself on this flag
  assign o_data_ready = f_ready; // R07

  // ----------------------------------------------------------------
  // generator selection
  // ----------------------------------------------------------------
  always_comb begin
    wide16 = 1'b0;
    case (st_q.sel)
      crc_pkg::SEL_CCITT: begin
        poly_w = crc_pkg::POLY_CCITT; // R01 R02
        wide16 = 1'b1;
      end
      crc_pkg::SEL_CRC16: begin
        poly_w = crc_pkg::POLY_CRC16; // R01 R03
        wide16 = 1'b1;
      end
      crc_pkg::SEL_CRC32: begin
        poly_w = crc_pkg::POLY_CRC32; // R01 R04
      end
      default: begin
        poly_w = st_q.poly; // R12
      end
    endcase
  end

  // ----------------------------------------------------------------
  // byte feed: lowest byte of the held word first
  // ----------------------------------------------------------------
  always_comb begin
    tb = st_q.sh[7:0]; // R13
    if (st_q.in_rev) begin
      tb = {<<{tb}}; // R05
    end
    if (st_q.in_cmp) begin
      tb = ~tb; // R05
    end
  end

  // bytes per queued entry, exactly the written width
  always_comb begin
    case (f_data[EW-1 -: 2])
      crc_pkg::SZ_BYTE: nbytes = 3'h1; // R08 R09
      crc_pkg::SZ_HALF: nbytes = 3'h2; // R08 R10
      default:          nbytes = 3'h4; // R08 R11
    endcase
  end

  // next word is taken while the last byte of the current one steps
  assign step = (st_q.state == ST_RUN);
  assign pop  = f_valid && (st_q.cnt <= 3'h1);

  // ----------------------------------------------------------------
  // checksum as software sees it
  // ----------------------------------------------------------------
  always_comb begin
    sum_plain = wide16 ? {16'h0000, st_q.acc[31:16]} : st_q.acc;
    sum_out   = sum_plain;
    if (st_q.out_rev) begin
      // reversing the left-aligned sum lands it right-aligned
      sum_out = wide16 ? {<<{{st_q.acc[31:16], 16'h0000}}}
                       : {<<{st_q.acc}}; // R05
    end
    if (st_q.out_cmp) begin
      sum_out = sum_out ^ (wide16 ? crc_pkg::MASK_16
                                  : crc_pkg::MASK_32); // R05
    end
  end

  // ----------------------------------------------------------------
  // next state: stepper, register writes, read data
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;

    // one byte per clock while running
    if (step) begin
      st_d.acc = crc_step(st_q.acc, tb, poly_w); // R09 R10 R11
      st_d.sh  = st_q.sh >> 8; // R13
      st_d.cnt = st_q.cnt - 3'h1;
    end
    if (pop) begin
      st_d.sh  = f_data[31:0];
      st_d.cnt = nbytes; // R08
    end
    st_d.state = (st_d.cnt != 3'h0) ? ST_RUN : ST_IDLE;

    // register writes
    if (i_wr) begin
      case (i_addr)
        crc_pkg::ADDR_CTRL: begin
          st_d.sel     = i_wdata[crc_pkg::CTRL_SEL_LSB +: 2]; // R01
          st_d.in_rev  = i_wdata[crc_pkg::CTRL_IN_REV];
          st_d.in_cmp  = i_wdata[crc_pkg::CTRL_IN_CMP];
          st_d.out_rev = i_wdata[crc_pkg::CTRL_OUT_REV];
          st_d.out_cmp = i_wdata[crc_pkg::CTRL_OUT_CMP];
        end
        crc_pkg::ADDR_SEED: begin
          // seed wins over a byte step in the same clock
          st_d.acc = wide16 ? {i_wdata[15:0], 16'h0000}
                            : i_wdata; // R06
        end
        crc_pkg::ADDR_POLY: begin
          st_d.poly = i_wdata; // R12
        end
        crc_pkg::ADDR_STAT: begin
          if (i_wdata[crc_pkg::STAT_OVF]) begin
            st_d.ovf = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // a lost data write sets the flag after any clear
    if (wr_data && size_ok && !f_ready) begin
      st_d.ovf = 1'b1;
    end

    // read data stand for one cycle only
    st_d.rdata = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        crc_pkg::ADDR_CTRL: begin
          st_d.rdata[crc_pkg::CTRL_SEL_LSB +: 2] = st_q.sel;
          st_d.rdata[crc_pkg::CTRL_IN_REV]       = st_q.in_rev;
          st_d.rdata[crc_pkg::CTRL_IN_CMP]       = st_q.in_cmp;
          st_d.rdata[crc_pkg::CTRL_OUT_REV]      = st_q.out_rev;
          st_d.rdata[crc_pkg::CTRL_OUT_CMP]      = st_q.out_cmp;
        end
        crc_pkg::ADDR_SEED: begin
          st_d.rdata = sum_plain;
        end
        crc_pkg::ADDR_SUM: begin
          st_d.rdata = sum_out; // R05 R13
        end
        crc_pkg::ADDR_POLY: begin
          st_d.rdata = st_q.poly;
        end
        crc_pkg::ADDR_STAT: begin
          st_d.rdata[crc_pkg::STAT_BUSY] = step || f_valid; // R13
          st_d.rdata[crc_pkg::STAT_OVF]  = st_q.ovf;
          st_d.rdata[crc_pkg::STAT_LVL_LSB +: LW] = f_level;
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  // the 32-bit code drives its own generator
  a_sel_poly: assert property ( // R01
    (st_q.sel == crc_pkg::SEL_CRC32) |-> (poly_w == crc_pkg::POLY_CRC32))
    else $error("fixed generator select wrong");

  // a lone one bit into a cleared sum leaves the generator behind
  a_ccitt_taps: assert property ( // R02
    step && (st_q.acc == '0) && (tb == 8'h01) && !i_wr &&
    (st_q.sel == crc_pkg::SEL_CCITT) |=> (st_q.acc == 32'h1021_0000))
    else $error("ccitt generator taps wrong");

  a_crc16_taps: assert property ( // R03
    step && (st_q.acc == '0) && (tb == 8'h01) && !i_wr &&
    (st_q.sel == crc_pkg::SEL_CRC16) |=> (st_q.acc == 32'h8005_0000))
    else $error("crc16 generator taps wrong");

  a_crc32_taps: assert property ( // R04
    step && (st_q.acc == '0) && (tb == 8'h01) && !i_wr &&
    (st_q.sel == crc_pkg::SEL_CRC32) |=> (st_q.acc == 32'h04c1_1db7))
    else $error("crc32 generator taps wrong");

  a_prog_taps: assert property ( // R12
    step && (st_q.acc == '0) && (tb == 8'h01) && !i_wr &&
    (st_q.sel == crc_pkg::SEL_PROG) |=> (st_q.acc == $past(st_q.poly)))
    else $error("programmed generator not used");

  // inverted input without reversal feeds the complement of the byte
  a_in_invert: assert property ( // R05
    step && st_q.in_cmp && !st_q.in_rev |-> (tb == ~st_q.sh[7:0]))
    else $error("input complement wrong");

  // sum read with complement only
  a_out_invert: assert property ( // R05
    i_rd && (i_addr == crc_pkg::ADDR_SUM) && st_q.out_cmp &&
    !st_q.out_rev && (st_q.sel == crc_pkg::SEL_CRC32)
    |=> (o_rdata == ~$past(st_q.acc)))
    else $error("sum complement wrong");

  a_seed_load: assert property ( // R06
    i_wr && (i_addr == crc_pkg::ADDR_SEED) &&
    (st_q.sel == crc_pkg::SEL_CRC32) |=> (st_q.acc == $past(i_wdata)))
    else $error("seed not loaded");

  a_byte_time: assert property ( // R09
    pop && (f_data[EW-1 -: 2] == crc_pkg::SZ_BYTE)
    |=> (st_q.cnt == 3'h1) && step)
    else $error("byte write not one step");

  a_half_time: assert property ( // R10
    pop && (f_data[EW-1 -: 2] == crc_pkg::SZ_HALF)
    |=> (st_q.cnt == 3'h2) ##1 (st_q.cnt == 3'h1))
    else $error("halfword write not two steps");

  a_word_time: assert property ( // R11
    pop && (f_data[EW-1 -: 2] == crc_pkg::SZ_WORD)
    |=> (st_q.cnt == 3'h4) ##1 (st_q.cnt == 3'h3)
    ##1 (st_q.cnt == 3'h2) ##1 (st_q.cnt == 3'h1))
    else $error("word write not four steps");

  // the held word moves down one byte per step
  a_lsb_first: assert property ( // R13
    step && (st_q.cnt > 3'h1) |=> (st_q.sh[23:0] == $past(st_q.sh[31:8])))
    else $error("byte order wrong");

endmodule : crc_engine

`default_nettype wire

// ===== include/crc_pkg.sv
// constants shared by the checksum engine and the bench models
`default_nettype none

package crc_pkg;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 16;

  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SEED = 8'h04;
  localparam logic [7:0] ADDR_SUM  = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam logic [7:0] ADDR_POLY = 8'h10;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SEL_LSB = 0;
  localparam int unsigned CTRL_IN_REV  = 2;
  localparam int unsigned CTRL_IN_CMP  = 3;
  localparam int unsigned CTRL_OUT_REV = 4;
  localparam int unsigned CTRL_OUT_CMP = 5;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_OVF     = 1;
  localparam int unsigned STAT_LVL_LSB = 8;

  // ----------------------------------------------------------------
  // polynomial select codes and left-aligned generators
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_CCITT = 2'h0;
  localparam logic [1:0] SEL_CRC16 = 2'h1;
  localparam logic [1:0] SEL_CRC32 = 2'h2;
  localparam logic [1:0] SEL_PROG  = 2'h3;

  localparam logic [31:0] POLY_CCITT = 32'h1021_0000;
  localparam logic [31:0] POLY_CRC16 = 32'h8005_0000;
  localparam logic [31:0] POLY_CRC32 = 32'h04c1_1db7;

  // ----------------------------------------------------------------
  // write sizes of the data register
  // ----------------------------------------------------------------
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;

  // ----------------------------------------------------------------
  // reset values and output complement masks
  // ----------------------------------------------------------------
  localparam logic [1:0]  SEL_RST  = 2'h2;
  localparam logic [31:0] POLY_RST = 32'h04c1_1db7;
  localparam logic [31:0] SEED_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_16  = 32'h0000_ffff;
  localparam logic [31:0] MASK_32  = 32'hffff_ffff;

endpackage : crc_pkg

`default_nettype wire

// ===== design/crc_fifo.sv
// data queue between the register port and the byte stepper
`default_nettype none

module crc_fifo #(
  parameter int unsigned WIDTH = 34,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst_b,
  input  wire logic                         i_valid,
  input  wire logic [WIDTH-1:0]             i_data,
  output logic                              o_ready,
  output logic                              o_valid,
  output logic [WIDTH-1:0]                  o_data,
  input  wire logic                         i_ready,
  output logic [$clog2(DEPTH+1)-1:0]        o_level
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned LW = $clog2(DEPTH + 1);

  // refuse depths the pointer wrap cannot serve
  if ((DEPTH < 2) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_bad_depth
    $error("crc_fifo depth must be a power of two, at least two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [LW-1:0]               lvl;
    logic                        rdy;
  } fifo_st_t;

  localparam fifo_st_t RST = fifo_st_t'(1); // empty, ready

  fifo_st_t st_q;
  fifo_st_t st_d;
  logic     push;
  logic     pop;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    push = i_valid && st_q.rdy;
    pop  = i_ready && (st_q.lvl != '0);
    if (push) begin
      st_d.mem[st_q.wp] = i_data;
      st_d.wp           = st_q.wp + 1'b1;
    end
    if (pop) begin
      st_d.rp = st_q.rp + 1'b1;
    end
    st_d.lvl = st_q.lvl + LW'(push) - LW'(pop);
    st_d.rdy = (st_d.lvl != LW'(DEPTH)); // back-pressure to the source
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      st_q <= RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from state
  assign o_ready = st_q.rdy;
  assign o_valid = (st_q.lvl != '0);
  assign o_data  = st_q.mem[st_q.rp];
  assign o_level = st_q.lvl;

endmodule : crc_fifo

`default_nettype wire

// ===== bench/crc_bus_master.sv
// bus master model: programmed register access and paced queue writes
`default_nettype none

module crc_bus_master (
  input  wire logic                       i_clk,
  input  wire logic [31:0]                i_rdata,
  input  wire logic                       i_data_ready,
  output logic      [crc_pkg::ADDR_W-1:0] o_addr,
  output logic      [31:0]                o_wdata,
  output logic      [1:0]                 o_size,
  output logic                            o_wr,
  output logic                            o_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  int stall_count = 0;  // cycles spent waiting on a full queue

  // quiet bus from time zero
  initial begin
    o_addr  = '0;
    o_wdata = '0;
    o_size  = '0;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // write; strobe stays up so another write may follow with no gap
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] s);
    o_addr  <= a;
    o_wdata <= d;
    o_size  <= s;
    o_wr    <= 1'b1;
    o_rd    <= 1'b0;
    @(posedge i_clk);
  endtask : wr

  // one cycle with both strobes low
  task automatic idle();
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    @(posedge i_clk);
  endtask : idle

  // read; the reply is taken at the edge that closes the reply cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    o_addr <= a;
    o_wr   <= 1'b0;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask : rd

  // paced queue write: ready is looked at once the last write landed,
  // so a full queue is never written
  task automatic dma_word(input logic [31:0] d);
    int n;
    n = 0;
    @(negedge i_clk);
    while (i_data_ready !== 1'b1 && n < 1000) begin
      stall_count++;
      n++;
      @(negedge i_clk);
    end
    @(posedge i_clk);
    o_addr  <= crc_pkg::ADDR_DATA;
    o_wdata <= d;
    o_size  <= crc_pkg::SZ_WORD;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask : dma_word

endmodule : crc_bus_master

`default_nettype wire

// ===== bench/crc_engine_tb.sv
// self-checking bench for the checksum engine
`default_nettype none

module crc_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] PROG_POLY = 32'h1edc_6f41;

  logic        i_clk = 1'b0;
  logic        i_rst_b = 1'b0;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [1:0]  size;
  logic        wr_s;
  logic        rd_s;
  logic [31:0] rdata;
  logic        data_ready;
  int          fail_count = 0;
  int          comparisons = 0;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  crc_engine #(.FIFO_DEPTH(16)) crc_engine_inst (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_wdata(wdata),
    .i_size(size), .i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata),
    .o_data_ready(data_ready));

  crc_bus_master crc_bus_master_inst (
    .i_clk(i_clk), .i_rdata(rdata), .i_data_ready(data_ready),
    .o_addr(addr), .o_wdata(wdata), .o_size(size), .o_wr(wr_s),
    .o_rd(rd_s));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check_word(input logic [31:0] got,
                            input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %h want %h",
               $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp,
                           input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s got %b", $time, what, got);
    end
  endtask : check_bit

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] s);
    crc_bus_master_inst.wr(a, d, s);
  endtask : wr

  task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp,
                            input string what);
    logic [31:0] r;
    crc_bus_master_inst.rd(a, r);
    check_word(r, exp, what);
  endtask : expect_reg

  // poll the busy bit under a bound
  task automatic wait_idle();
    logic [31:0] s;
    int n;
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0) begin
      crc_bus_master_inst.rd(crc_pkg::ADDR_STAT, s);
      n++;
      if (n > 300) begin
        fail_count++;
        $display("wrong value at %0t: engine stays busy", $time);
        summarize();
      end
    end
  endtask : wait_idle

  task automatic do_reset();
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
  endtask : do_reset

  // one byte step of the reference, most significant bit first
  function automatic logic [31:0] fold(input logic [31:0] acc,
                                       input logic [7:0]  b,
                                       input logic [5:0]  ctl);
    logic [31:0] g;
    logic [31:0] x;
    case (ctl[1:0])
      2'h0:    g = 32'h1021_0000;
      2'h1:    g = 32'h8005_0000;
      2'h2:    g = 32'h04c1_1db7;
      default: g = PROG_POLY;
    endcase
    if (ctl[2])
      b = {<<{b}};
    if (ctl[3])
      b = ~b;
    x = ctl[1] ? acc : {acc[15:0], 16'h0000};
    x = x ^ {b, 24'h00_0000};
    for (int i = 0; i < 8; i++)
      x = x[31] ? ((x << 1) ^ g) : (x << 1);
    return ctl[1] ? x : {16'h0000, x[31:16]};
  endfunction : fold

  // sum as software sees it after the output transforms
  function automatic logic [31:0] shown(input logic [31:0] acc,
                                        input logic [5:0]  ctl);
    logic [31:0] v;
    v = acc;
    if (ctl[4])
      v = {<<{v}};
    if (!ctl[1])
      v = ctl[4] ? {16'h0000, v[31:16]} : {16'h0000, v[15:0]};
    if (ctl[5])
      v = ~v;
    if (!ctl[1])
      v[31:16] = 16'h0000;
    return v;
  endfunction : shown

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [31:0] acc;
    logic [31:0] w;
    logic [5:0]  ctl;
    logic [3:0]  tr [4];
    logic [7:0]  bl [7];
    tr = '{4'h0, 4'hf, 4'h5, 4'ha};
    bl = '{8'ha5, 8'h34, 8'h12, 8'hef, 8'hbe, 8'had, 8'hde};
    do_reset();
    check_bit(data_ready, 1'b1, "ready after reset");
    expect_reg(crc_pkg::ADDR_CTRL, 32'h0000_0002, "ctrl reset");
    expect_reg(crc_pkg::ADDR_POLY, 32'h04c1_1db7, "poly reset");
    expect_reg(crc_pkg::ADDR_STAT, 32'h0000_0000, "stat reset");
    wr(8'h18, 32'hffff_ffff, 2'h0);
    wr(crc_pkg::ADDR_SUM, 32'h1234_5678, 2'h0);
    expect_reg(8'h18, 32'h0000_0000, "unmapped");
    expect_reg(crc_pkg::ADDR_SEED, 32'h0000_0000, "seed kept");
    // every generator with several transform mixes and all sizes
    for (int m = 0; m < 16; m++) begin
      ctl = {tr[m[3:2]], m[1:0]};
      wr(crc_pkg::ADDR_CTRL, {26'h0, ctl}, 2'h0);
      wr(crc_pkg::ADDR_POLY, PROG_POLY, 2'h0);
      wr(crc_pkg::ADDR_SEED, 32'h1d0f_5a5a, 2'h0);
      wr(crc_pkg::ADDR_DATA, 32'h7788_99a5, crc_pkg::SZ_BYTE);
      wr(crc_pkg::ADDR_DATA, 32'hcafe_1234, crc_pkg::SZ_HALF);
      wr(crc_pkg::ADDR_DATA, 32'hdead_beef, crc_pkg::SZ_WORD);
      wr(crc_pkg::ADDR_DATA, 32'h0bad_0bad, 2'h3);
      acc = ctl[1] ? 32'h1d0f_5a5a : 32'h0000_5a5a;
      foreach (bl[j])
        acc = fold(acc, bl[j], ctl);
      wait_idle();
      expect_reg(crc_pkg::ADDR_SUM, shown(acc, ctl), "sum");
      expect_reg(crc_pkg::ADDR_SEED, acc, "raw sum");
      expect_reg(crc_pkg::ADDR_CTRL, {26'h0, ctl}, "ctrl");
      // lone one bit into a cleared sum leaves the bare generator
      if (m < 4) begin
        wr(crc_pkg::ADDR_SEED, 32'h0000_0000, 2'h0);
        wr(crc_pkg::ADDR_DATA, 32'h0000_0001, crc_pkg::SZ_BYTE);
        wait_idle();
        r = fold(32'h0000_0000, 8'h01, ctl);
        expect_reg(crc_pkg::ADDR_SUM, r, "lone bit");
      end
    end
    // busy on the last byte step, clear one cycle later
    for (int s = 0; s < 3; s++) begin
      for (int late = 0; late < 2; late++) begin
        wr(crc_pkg::ADDR_DATA, 32'h0102_0304, s[1:0]);
        repeat ((1 << s) + late) crc_bus_master_inst.idle();
        crc_bus_master_inst.rd(crc_pkg::ADDR_STAT, r);
        check_bit(r[0], late == 0, "busy timing");
        wait_idle();
      end
    end
    // paced stream until the queue refuses, then drained to empty
    wr(crc_pkg::ADDR_CTRL, 32'h0000_0002, 2'h0);
    wr(crc_pkg::ADDR_SEED, 32'hffff_ffff, 2'h0);
    crc_bus_master_inst.idle();
    acc = 32'hffff_ffff;
    for (int i = 0; i < 40; i++) begin
      w = {4{i[7:0]}} ^ 32'h1357_9bdf;
      crc_bus_master_inst.dma_word(w);
      for (int j = 0; j < 4; j++)
        acc = fold(acc, w[8*j +: 8], 6'h02);
    end
    check_bit(crc_bus_master_inst.stall_count > 0, 1'b1, "full");
    wait_idle();
    expect_reg(crc_pkg::ADDR_SUM, acc, "stream sum");
    expect_reg(crc_pkg::ADDR_STAT, 32'h0000_0000, "queue empty");
    // unpaced writes overrun the queue
    for (int i = 0; i < 24; i++)
      wr(crc_pkg::ADDR_DATA, 32'h0000_0000, crc_pkg::SZ_WORD);
    wait_idle();
    expect_reg(crc_pkg::ADDR_STAT, 32'h0000_0002, "overflow");
    wr(crc_pkg::ADDR_STAT, 32'h0000_0002, 2'h0);
    expect_reg(crc_pkg::ADDR_STAT, 32'h0000_0000, "overflow clear");
    // second reset with the engine idle
    do_reset();
    expect_reg(crc_pkg::ADDR_CTRL, 32'h0000_0002, "ctrl reset 2");
    expect_reg(crc_pkg::ADDR_SUM, 32'h0000_0000, "sum reset");
    summarize();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #200us;
    fail_count++;
    $display("wrong value at %0t: run did not finish", $time);
    summarize();
  end

endmodule : crc_engine_tb

`default_nettype wire
